// file: pm_phy_ctrl_defs.vh
// Offsets, field positions, reset values for power management and PHY control registers
`ifndef PM_PHY_CTRL_DEFS_VH
`define PM_PHY_CTRL_DEFS_VH
`define PMCS_OFFSET 8'h48
`define PMEXT_OFFSET 8'h4a
`define PHYCTL_OFFSET 8'hec
`define EEPROM_PHY_BYTE 8'h16
`define PMCS_FLAG_BIT 15
`define PMCS_ENABLE_BIT 8
`define PMCS_STATE_HI 1
`define PMCS_STATE_LO 0
`define PHYCTL_ROUTE_BIT 7
`define PHYCTL_REV_BIT 3
`define PHYCTL_RESET 32'h00000008
`define PMCS_RESET 16'h0000
`define PMEXT_VALUE 16'h0000
`define WAKE_SUPPORT_MASK 4'hf
`endif

// file: pm_phy_ctrl_regs.v
// Power management control/status, extension and PHY control configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "pm_phy_ctrl_defs.vh"

// Register map on the configuration bus, byte addresses:
//   Offset 48h: power management control/status in bits 15-0, extension word in 31-16
//   Offset 4Ah: power management extension, read-only zero
//   Offset ECh: PHY output control; bit 7 routes the cable indication, bit 3 reads 1 after reset, then the loaded EEPROM bit
// Any other address reads zero and ignores writes, so a stray access is harmless.
// Writes take effect at the edge that samples cfg_wr_in with clk_en_in high.
// Read data appears after the edge that samples cfg_rd_in and holds until the next read.
// The EEPROM loader owns the whole PHY byte at boot; only the route bit is left to the host.
// Everything runs in the one configuration clock; all inputs but the asynchronous rst_in are taken as synchronous.
// With clk_en_in low every flop holds, including the read data and the cable output.
// The internal D3hot reset and the D3cold strap touch no flop; see the enable process.
// The wake output is a plain AND of two flops, so it never glitches on its own.

module pm_phy_ctrl_regs (
  // Clock, reset, enable
  input wire sys_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  input wire d3hot_reset_in,
  input wire d3cold_wake_support_in,
  // Configuration access
  input wire cfg_rd_in,
  input wire cfg_wr_in,
  input wire [7:0] cfg_addr_in,
  input wire [31:0] cfg_wdata_in,
  input wire [3:0] cfg_be_in,
  output reg [31:0] cfg_rdata_out,
  // EEPROM loader
  input wire eeprom_load_in,
  input wire [7:0] eeprom_data_in,
  // Events and pins
  input wire wake_event_in,
  input wire cable_not_active_indication_in,
  output wire wake_event_out,
  output reg cable_not_active_out,
  output wire [1:0] power_state_field_out,
  output wire [3:0] wake_state_support_mask_out
);

  // Constants derived from the shared header, so masks follow the field positions
  // and a moved bit cannot leave a stale mask behind
  localparam [15:0] PMCS_RESET_WORD = `PMCS_RESET;
  localparam [31:0] PHY_RESET_WORD = `PHYCTL_RESET;
  localparam [7:0] PHY_RESET_BYTE = PHY_RESET_WORD[7:0];
  localparam [7:0] PHY_HOST_MASK = 8'h01 << `PHYCTL_ROUTE_BIT;
  localparam [7:0] PHY_READ_MASK = (8'h01 << `PHYCTL_ROUTE_BIT) | (8'h01 << `PHYCTL_REV_BIT);

  // Register state
  reg wake_event_flag_q;
  reg wake_event_flag_d;
  reg wake_assert_enable_q;
  reg [1:0] power_state_field_q;
  reg [31:0] rdata_d;

  // PHY control: route bit for the pin, and the byte as the host may see it
  wire cable_route;
  wire [7:0] phy_read;

  // Address decode, byte-lane qualified writes and wake event handling
  wire pmcs_wr;
  wire phy_wr;
  wire pmcs_lane0_wr;
  wire pmcs_lane1_wr;
  wire phy_lane0_wr;
  wire wake_accept;
  wire flag_clear;

  // Host-visible words for the extension and PHY offsets
  wire [15:0] pmext_word;
  wire [31:0] phy_word;

  // A write lands only in the byte lanes that are enabled
  assign pmcs_wr = cfg_wr_in && (cfg_addr_in == `PMCS_OFFSET);
  assign phy_wr = cfg_wr_in && (cfg_addr_in == `PHYCTL_OFFSET);
  assign pmcs_lane0_wr = pmcs_wr && cfg_be_in[0];
  assign pmcs_lane1_wr = pmcs_wr && cfg_be_in[1];
  assign phy_lane0_wr = phy_wr && cfg_be_in[0];
  // Write-one-to-clear; a 0 in the flag position is simply not a clear
  assign flag_clear = pmcs_lane1_wr && cfg_wdata_in[`PMCS_FLAG_BIT];
  // All four power states may raise a wake event, so no state gates the source
  assign wake_state_support_mask_out = `WAKE_SUPPORT_MASK;
  assign wake_accept = wake_event_in;
  // Output gated by enable; a clear releases it after the edge that takes the write, through the flag flop
  assign wake_event_out = wake_event_flag_q && wake_assert_enable_q;
  // Power state is reported straight from its flop
  assign power_state_field_out = power_state_field_q;
  // Extension is unimplemented; the PHY word shows only the visible bits
  assign pmext_word = `PMEXT_VALUE;
  assign phy_word = {24'h000000, phy_read};

  // Flag next state: an event in the same cycle as a write-one-to-clear keeps the flag
  // set, so software that clears and then re-reads never loses an event
  always @* begin
    wake_event_flag_d = wake_event_flag_q;
    if (wake_accept) begin
      wake_event_flag_d = 1'b1;
    end else if (flag_clear) begin
      wake_event_flag_d = 1'b0;
    end
  end

  // Control/status flops: d3hot_reset_in is deliberately left out, so the internal
  // reset on the way back from D3hot cannot disturb what software programmed
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_event_flag_q <= PMCS_RESET_WORD[`PMCS_FLAG_BIT];
      power_state_field_q <= PMCS_RESET_WORD[`PMCS_STATE_HI:`PMCS_STATE_LO];
    end else if (clk_en_in) begin
      wake_event_flag_q <= wake_event_flag_d;
      if (pmcs_lane0_wr) begin
        power_state_field_q <= cfg_wdata_in[`PMCS_STATE_HI:`PMCS_STATE_LO];
      end
    end
  end

  // Wake enable, reset only by rst_in, which stands for power-on here; the D3cold strap
  // is informational, since without an auxiliary-power reset the enable cannot tell a warm
  // reset from a cold one, so the operating system must clear it after power-up
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_assert_enable_q <= PMCS_RESET_WORD[`PMCS_ENABLE_BIT];
    end else if (clk_en_in) begin
      if (pmcs_lane1_wr) begin
        wake_assert_enable_q <= cfg_wdata_in[`PMCS_ENABLE_BIT];
      end
    end
  end

  // PHY control, one flop per bit: every bit takes the EEPROM byte, only host-writable
  // bits take the host, and a load wins over a host write in the same cycle, so a boot
  // image is never half overwritten
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_phy_bit
      reg bit_q;
      always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          bit_q <= PHY_RESET_BYTE[bit_idx];
        end else if (clk_en_in) begin
          if (eeprom_load_in) begin
            bit_q <= eeprom_data_in[bit_idx];
          end else if (phy_lane0_wr && PHY_HOST_MASK[bit_idx]) begin
            bit_q <= cfg_wdata_in[bit_idx];
          end
        end
      end
      // Reserved bits keep what was loaded but never show it
      assign phy_read[bit_idx] = bit_q && PHY_READ_MASK[bit_idx];
      // Only the route bit feeds the pin
      if (bit_idx == `PHYCTL_ROUTE_BIT) begin : g_route
        assign cable_route = bit_q;
      end
    end
  endgenerate

  // Cable indication pin, registered as a data output; it stays low while routing is
  // off, so a board that leaves the pin unconnected sees no toggling
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cable_not_active_out <= 1'b0;
    end else if (clk_en_in) begin
      cable_not_active_out <= cable_route && cable_not_active_indication_in;
    end
  end

  // Read mux; reserved bits read zero, unmapped offsets read zero
  always @* begin
    rdata_d = 32'h00000000;
    case (cfg_addr_in)
      `PMCS_OFFSET: begin
        rdata_d[`PMCS_FLAG_BIT] = wake_event_flag_q;
        rdata_d[`PMCS_ENABLE_BIT] = wake_assert_enable_q;
        rdata_d[`PMCS_STATE_HI:`PMCS_STATE_LO] = power_state_field_q;
        rdata_d[31:16] = pmext_word;
      end
      `PMEXT_OFFSET: begin
        rdata_d[15:0] = pmext_word;
      end
      `PHYCTL_OFFSET: begin
        rdata_d = phy_word;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data registered on the read edge; it stands until the next read, so a host
  // that takes it a few cycles late still sees the right word
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rdata_out <= 32'h00000000;
    end else if (clk_en_in && cfg_rd_in) begin
      cfg_rdata_out <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// file: pm_phy_ctrl_regs_asserts.sv
// Port checks for the power management and PHY control registers
`timescale 1ns/100ps
`default_nettype none
module pm_phy_ctrl_regs_asserts (
  input wire sys_clk_in, rst_in, clk_en_in, d3hot_reset_in, cfg_rd_in, cfg_wr_in, wake_event_in,
  input wire cable_not_active_indication_in, wake_event_out, cable_not_active_out,
  input wire [7:0] cfg_addr_in,
  input wire [31:0] cfg_wdata_in, cfg_rdata_out,
  input wire [3:0] cfg_be_in,
  input wire [1:0] power_state_field_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Strobes only count while the clock enable lets state move
  wire rd = cfg_rd_in & clk_en_in;
  wire wr = cfg_wr_in & clk_en_in;
  property p_clr; wr && cfg_addr_in == 8'h48 && cfg_be_in[1] && cfg_wdata_in[15] && !wake_event_in |=> !wake_event_out; endproperty
  a_clr: assert property (p_clr) else $error("wake output kept after clear");
  property p_rise; $rose(wake_event_out) |-> $past((wake_event_in && clk_en_in) || wr); endproperty
  a_rise: assert property (p_rise) else $error("wake output rose without cause");
  property p_cna; !cable_not_active_indication_in && clk_en_in |=> !cable_not_active_out; endproperty
  a_cna: assert property (p_cna) else $error("cable output without indication");
  property p_state; wr && cfg_addr_in == 8'h48 && cfg_be_in[0] |=> power_state_field_out == $past(cfg_wdata_in[1:0]); endproperty
  a_state: assert property (p_state) else $error("power state not written");
  property p_d3; d3hot_reset_in && !wr |=> $stable(power_state_field_out); endproperty
  a_d3: assert property (p_d3) else $error("state lost on internal reset");
  property p_ext; rd && cfg_addr_in == 8'h4a |=> cfg_rdata_out[15:0] == 16'h0000; endproperty
  a_ext: assert property (p_ext) else $error("extension not zero");
  property p_phy; rd && cfg_addr_in == 8'hec |=> cfg_rdata_out[31:8] == 24'h000000 && cfg_rdata_out[6:4] == 3'h0
    && cfg_rdata_out[2:0] == 3'h0; endproperty
  a_phy: assert property (p_phy) else $error("reserved PHY bits set");
  property p_pm; rd && cfg_addr_in == 8'h48 |=> cfg_rdata_out[14:9] == 6'h00 && cfg_rdata_out[7:2] == 6'h00; endproperty
  a_pm: assert property (p_pm) else $error("reserved status bits set");
endmodule
bind pm_phy_ctrl_regs pm_phy_ctrl_regs_asserts chk (.*);
`default_nettype wire

// file: eeprom_loader.sv
// Serial EEPROM loader model presenting the PHY control byte
`timescale 1ns/100ps
`default_nettype none
module eeprom_loader (
  input wire logic clk_in, go_in, route_in,
  output logic load_out = 1'b0,
  output logic [7:0] data_out = 8'h5a
);
  // Byte keeps bit 3 set and reserved bits clear; data scrambles when idle
  always @(posedge clk_in) begin
    load_out <= go_in;
    data_out <= go_in ? {route_in, 7'h08} : ~data_out;
  end
endmodule
`default_nettype wire

// file: pm_phy_ctrl_regs_tb.sv
// Self-checking bench for the power management and PHY control registers
`timescale 1ns/100ps
`default_nettype none
module pm_phy_ctrl_regs_tb;
  logic clk = 0, rst = 1, en = 1, rd = 0, wr = 0, wev = 0, cable_not_active_indication = 0, d3 = 0, go = 0, route = 0, ld, wout, cout;
  logic [7:0] addr = 0, edata;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] be = 0;
  logic [1:0] pst;
  logic [3:0] mask;
  int fails = 0, checked = 0;
  always #10 clk = ~clk;
  eeprom_loader ee (.clk_in(clk), .go_in(go), .route_in(route), .load_out(ld), .data_out(edata));
  pm_phy_ctrl_regs uut (.sys_clk_in(clk), .rst_in(rst), .clk_en_in(en), .d3hot_reset_in(d3),
    .d3cold_wake_support_in(1'b1), .cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
    .cfg_be_in(be), .cfg_rdata_out(rdata), .eeprom_load_in(ld), .eeprom_data_in(edata), .wake_event_in(wev),
    .cable_not_active_indication_in(cable_not_active_indication), .wake_event_out(wout), .cable_not_active_out(cout),
    .power_state_field_out(pst), .wake_state_support_mask_out(mask));
  task step; @(posedge clk) #2; endtask
  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin fails++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  // One configuration cycle; strobes then rest one idle edge, so the next call never re-raises them
  // in the time step that dropped them; read data stands until the next read
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    wr = w; rd = !w; addr = a; wdata = d; be = b;
    step; wr = 0; rd = 0;
    step;
  endtask
  task wrap_up;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #2 rst = 0;
    acc(0, 8'hec, 0, 0); chk(rdata, 32'h00000008);
    chk(mask, 4'hf);
    acc(1, 8'h4a, 32'hffffffff, 4'hf); acc(0, 8'h4a, 0, 0); chk(rdata, 32'h0);
    acc(1, 8'hec, 32'hffffffff, 4'hf); acc(0, 8'hec, 0, 0); chk(rdata, 32'h88);
    cable_not_active_indication = 1; step; chk(cout, 1);
    // Loader takes the byte two edges after the request
    for (int i = 0; i < 2; i++) begin
      route = !i; go = 1; step; go = 0; step;
      acc(0, 8'hec, 0, 0); chk(rdata, {24'h0, route, 7'h08}); chk(cout, route);
    end
    for (int i = 0; i < 4; i++) begin
      acc(1, 8'h48, 32'h00007ffc | i, 4'h3); acc(0, 8'h48, 0, 0); chk(rdata, 32'h100 | i);
      chk(pst, i);
    end
    wev = 1; step; wev = 0; chk(wout, 1);
    d3 = 1; step; d3 = 0; acc(0, 8'h48, 0, 0); chk(rdata, 32'h8103);
    acc(1, 8'h48, 32'h00008103, 4'h3); chk(wout, 0);
    acc(1, 8'h48, 32'h00000003, 4'h3); wev = 1; step; wev = 0; chk(wout, 0);
    acc(0, 8'h48, 0, 0); chk(rdata, 32'h8003);
    en = 0; acc(1, 8'h48, 32'h00008000, 4'h3); wev = 1; step; wev = 0; en = 1;
    acc(0, 8'h48, 0, 0); chk(rdata, 32'h8003);
    acc(1, 8'h48, 32'h00000103, 4'h3); chk(wout, 1);
    rst = 1; step; rst = 0; acc(0, 8'h48, 0, 0); chk(rdata, 32'h0);
    wrap_up;
  end
endmodule
`default_nettype wire
